// [rtl/srsr_pkg.sv]
package srsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the internal register port
  // ----------------------------------------------------------------
  localparam logic [7:0] INIT_PROGRESS_OFS  = 8'hE0;  // Init progress flags
  localparam logic [7:0] FAULT_LIVE_OFS     = 8'hE1;  // Live safety faults
  localparam logic [7:0] FAULT_STICKY_OFS   = 8'hE2;  // Sticky safety faults
  localparam logic [7:0] PIN_MIRROR_OFS     = 8'hE4;  // Pin level mirror
  localparam logic [7:0] RAW_TEMP_OFS       = 8'hE6;  // Raw temperature
  localparam logic [7:0] RAW_SUPPLY_OFS     = 8'hE7;  // Raw supply
  localparam logic [7:0] RAW_BIAS_OFS       = 8'hE8;  // Raw bias current
  localparam logic [7:0] RAW_TX_OPT_OFS     = 8'hE9;  // Raw tx optical power
  localparam logic [7:0] RAW_RX_OPT_OFS     = 8'hEA;  // Raw rx optical power
  localparam logic [7:0] RAW_PD_VOLT_OFS    = 8'hEB;  // Raw photodiode voltage
  localparam logic [7:0] SOFT_FAULT_OFS     = 8'hC0;  // Software fault control

  // ----------------------------------------------------------------
  // Init progress field positions
  // ----------------------------------------------------------------
  localparam int INIT_LOADER_IDLE_BIT = 5;  // Loader idle
  localparam int INIT_RESV4_BIT       = 4;  // Reserved, reads one
  localparam int INIT_TX_UP_BIT       = 3;  // Tx power-up done
  localparam int INIT_RX_UP_BIT       = 2;  // Rx power-up done
  localparam int INIT_CRC_FAIL_BIT    = 1;  // Integrity check failed
  localparam int INIT_NO_ACK_BIT      = 0;  // No address acknowledge

  // ----------------------------------------------------------------
  // Safety fault field positions (live and sticky share them)
  // ----------------------------------------------------------------
  localparam int FLT_ALARM_BIT   = 7;
  localparam int FLT_ROGUE_BIT   = 6;
  localparam int FLT_SOFT_BIT    = 5;
  localparam int FLT_DISABLE_BIT = 4;
  localparam int FLT_SUPPLY_BIT  = 3;
  localparam int FLT_REF_BIT     = 2;
  localparam int FLT_LOOP_BIT    = 1;
  localparam int FLT_BIAS_BIT    = 0;
  localparam int FLT_WIDTH       = 8;

  // ----------------------------------------------------------------
  // Pin mirror field positions
  // ----------------------------------------------------------------
  localparam int PIN_SIG_DET_BIT  = 4;
  localparam int PIN_TX_FAULT_BIT = 3;
  localparam int PIN_SHUTDOWN_BIT = 2;
  localparam int PIN_SLEEP_BIT    = 1;
  localparam int PIN_TX_DIS_BIT   = 0;
  localparam int PIN_COUNT        = 4;  // External pins mirrored

  // ----------------------------------------------------------------
  // Reset values and misc
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET_VAL    = 8'h00;
  localparam logic [7:0] UNMAPPED_RD_VAL  = 8'h00;
  localparam int         SOFT_FAULT_BIT   = 0;  // Control bit in C0h
  localparam int         SYNC_STAGES      = 2;

endpackage : srsr_pkg

// [rtl/srsr_sync.sv]
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser, one per bit; first stage feeds only the second
module srsr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;  // First stage, read only by second

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Each bit gets its own pair of flops
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule : srsr_sync

`default_nettype wire

// [rtl/srsr_sticky.sv]
`timescale 1ns/100ps
`default_nettype none

// Sticky event flags with write-one-to-clear
module srsr_sticky #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic [WIDTH-1:0] clear_mask,
  output logic      [WIDTH-1:0] flags
);

  // ----------------------------------------------------------------
  // Per-bit flag
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // Set wins over clear so a coincident event survives
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          flags[i] <= 1'b0;
        end else if (event_in[i]) begin
          flags[i] <= 1'b1;
        end else if (clear_mask[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : srsr_sticky

`default_nettype wire

// [rtl/srsr_regs.sv]
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Bit 5 shows loader idle, zero at reset
// - Bit 3 shows tx power-up finished
// - Bit 2 shows rx power-up finished
// - Bit 1 flags load integrity failure
// - Bit 0 flags missing load acknowledge
// - Live fault register mirrors safety inputs
// - Sticky faults latch each asserted condition
// - Writing one clears sticky bit only
// - Pin mirror shows four live pin levels
// - Bit 2 mirrors internal laser shutdown
// - Raw temperature sample readable
// - Raw supply sample readable
// - Raw bias sample readable
// - Raw tx optical sample readable
// - Raw rx optical sample readable
// - Raw photodiode voltage readable
// - Software fault bit drives fault bit 5
module srsr_regs (
  input  wire logic       ref_clk,           // 125 MHz device clock
  input  wire logic       srst,              // Synchronous reset, high
  // Register port from the serial interface
  input  wire logic [7:0] reg_addr,          // Register offset
  input  wire logic       reg_wr_en,         // Write strobe, one cycle
  input  wire logic [7:0] reg_wr_data,       // Write data
  input  wire logic       reg_rd_en,         // Read strobe, one cycle
  output logic      [7:0] reg_rd_data,       // Read data, next cycle
  output logic            reg_rd_valid,      // Read data valid pulse
  // Initialisation progress from the loader and power-up sequencer
  input  wire logic       loader_idle,       // Transfer engine idle
  input  wire logic       tx_powerup_done,   // Tx path powered up
  input  wire logic       rx_powerup_done,   // Rx path powered up
  input  wire logic       load_crc_fail,     // Integrity check failed
  input  wire logic       load_no_ack,       // No address acknowledge
  // Laser safety conditions from internal logic
  input  wire logic       flt_alarm,         // Alarm condition
  input  wire logic       flt_rogue,         // Rogue unit condition
  input  wire logic       flt_disable,       // Disable request
  input  wire logic       flt_supply,        // Supply fault
  input  wire logic       flt_ref,           // Reference fault
  input  wire logic       flt_loop,          // Power loop fault
  input  wire logic       flt_bias,          // Bias fault
  input  wire logic       laser_shutdown,    // Internal shutdown signal
  // Device pins, asynchronous
  input  wire logic       pin_sig_det,       // Transmit signal-detect pin
  input  wire logic       pin_tx_fault,      // Transmit fault pin
  input  wire logic       pin_sleep,         // Sleep pin
  input  wire logic       pin_tx_disable,    // Transmit disable pin
  // Raw measurement samples from the converter
  input  wire logic [7:0] raw_temp,          // Temperature sample
  input  wire logic [7:0] raw_supply,        // Supply sample
  input  wire logic [7:0] raw_bias,          // Bias current sample
  input  wire logic [7:0] raw_tx_opt,        // Tx power before re-ranging
  input  wire logic [7:0] raw_rx_opt,        // Rx power sample
  input  wire logic [7:0] raw_pd_volt,       // Photodiode bias voltage
  // Software fault request to the safety logic
  output logic            soft_fault_out     // Software fault condition
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]                    init_reg;        // Init progress image
  logic [7:0]                    live_reg;        // Live fault image
  logic [7:0]                    pin_reg;         // Pin mirror image
  logic [7:0]                    temp_reg;        // Latched raw samples
  logic [7:0]                    supply_reg;
  logic [7:0]                    bias_reg;
  logic [7:0]                    tx_opt_reg;
  logic [7:0]                    rx_opt_reg;
  logic [7:0]                    pd_volt_reg;
  logic                          soft_fault_reg;  // Software fault control
  logic [7:0]                    live_next;       // Assembled fault vector
  logic [7:0]                    sticky_clr;      // Write-one-clear mask
  logic [7:0]                    sticky_flags;    // Sticky fault bits
  logic [srsr_pkg::PIN_COUNT-1:0] pins_raw;       // Pins before sync
  logic [srsr_pkg::PIN_COUNT-1:0] pins_sync;      // Pins after sync
  logic [7:0]                    rd_next;         // Read mux result

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // Pins come from outside the clock domain
  assign pins_raw = {pin_sig_det, pin_tx_fault, pin_sleep, pin_tx_disable};

  srsr_sync #(
    .WIDTH (srsr_pkg::PIN_COUNT)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  // ----------------------------------------------------------------
  // Software fault control register
  // ----------------------------------------------------------------
  // Writable bit that raises the software fault condition
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      soft_fault_reg <= 1'b0;
    end else if (reg_wr_en && reg_addr == srsr_pkg::SOFT_FAULT_OFS) begin
      soft_fault_reg <= reg_wr_data[srsr_pkg::SOFT_FAULT_BIT];
    end
  end

  // Drive the software fault to the safety logic
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      soft_fault_out <= 1'b0;
    end else begin
      soft_fault_out <= soft_fault_reg;
    end
  end

  // ----------------------------------------------------------------
  // Fault vector assembly
  // ----------------------------------------------------------------
  // Fixed bit order shared by live and sticky images
  always_comb begin
    live_next                            = 8'h00;
    live_next[srsr_pkg::FLT_ALARM_BIT]   = flt_alarm;
    live_next[srsr_pkg::FLT_ROGUE_BIT]   = flt_rogue;
    live_next[srsr_pkg::FLT_SOFT_BIT]    = soft_fault_reg;
    live_next[srsr_pkg::FLT_DISABLE_BIT] = flt_disable;
    live_next[srsr_pkg::FLT_SUPPLY_BIT]  = flt_supply;
    live_next[srsr_pkg::FLT_REF_BIT]     = flt_ref;
    live_next[srsr_pkg::FLT_LOOP_BIT]    = flt_loop;
    live_next[srsr_pkg::FLT_BIAS_BIT]    = flt_bias;
  end

  // Live faults are sampled each cycle, never latched
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      live_reg <= srsr_pkg::REG_RESET_VAL;
    end else begin
      live_reg <= live_next;
    end
  end

  // ----------------------------------------------------------------
  // Sticky fault events
  // ----------------------------------------------------------------
  // Only ones in a write to the sticky offset clear bits
  always_comb begin
    if (reg_wr_en && reg_addr == srsr_pkg::FAULT_STICKY_OFS) begin
      sticky_clr = reg_wr_data;
    end else begin
      sticky_clr = 8'h00;
    end
  end

  // Fed from the registered live image so set and read stay aligned
  srsr_sticky #(
    .WIDTH (srsr_pkg::FLT_WIDTH)
  ) u_sticky (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .event_in   (live_reg),
    .clear_mask (sticky_clr),
    .flags      (sticky_flags)
  );

  // ----------------------------------------------------------------
  // Initialisation progress
  // ----------------------------------------------------------------
  // Reserved bit 4 reads one; idle clears at reset until loader reports
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      init_reg <= 8'h10;
    end else begin
      init_reg                                <= 8'h00;
      init_reg[srsr_pkg::INIT_RESV4_BIT]      <= 1'b1;
      init_reg[srsr_pkg::INIT_LOADER_IDLE_BIT] <= loader_idle;
      init_reg[srsr_pkg::INIT_TX_UP_BIT]      <= tx_powerup_done;
      init_reg[srsr_pkg::INIT_RX_UP_BIT]      <= rx_powerup_done;
      init_reg[srsr_pkg::INIT_CRC_FAIL_BIT]   <= load_crc_fail;
      init_reg[srsr_pkg::INIT_NO_ACK_BIT]     <= load_no_ack;
    end
  end

  // ----------------------------------------------------------------
  // Pin mirror
  // ----------------------------------------------------------------
  // Undefined upper bits read as zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_reg <= srsr_pkg::REG_RESET_VAL;
    end else begin
      pin_reg                              <= 8'h00;
      pin_reg[srsr_pkg::PIN_SIG_DET_BIT]   <= pins_sync[3];
      pin_reg[srsr_pkg::PIN_TX_FAULT_BIT]  <= pins_sync[2];
      pin_reg[srsr_pkg::PIN_SHUTDOWN_BIT]  <= laser_shutdown;
      pin_reg[srsr_pkg::PIN_SLEEP_BIT]     <= pins_sync[1];
      pin_reg[srsr_pkg::PIN_TX_DIS_BIT]    <= pins_sync[0];
    end
  end

  // ----------------------------------------------------------------
  // Raw samples
  // ----------------------------------------------------------------
  // Samples captured every cycle; the converter holds each until next
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      temp_reg    <= srsr_pkg::REG_RESET_VAL;
      supply_reg  <= srsr_pkg::REG_RESET_VAL;
      bias_reg    <= srsr_pkg::REG_RESET_VAL;
      tx_opt_reg  <= srsr_pkg::REG_RESET_VAL;
      rx_opt_reg  <= srsr_pkg::REG_RESET_VAL;
      pd_volt_reg <= srsr_pkg::REG_RESET_VAL;
    end else begin
      temp_reg    <= raw_temp;
      supply_reg  <= raw_supply;
      bias_reg    <= raw_bias;
      tx_opt_reg  <= raw_tx_opt;
      rx_opt_reg  <= raw_rx_opt;
      pd_volt_reg <= raw_pd_volt;
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Unmapped offsets answer zero rather than stale data
  always_comb begin
    if (reg_addr == srsr_pkg::INIT_PROGRESS_OFS) begin
      rd_next = init_reg;
    end else if (reg_addr == srsr_pkg::FAULT_LIVE_OFS) begin
      rd_next = live_reg;
    end else if (reg_addr == srsr_pkg::FAULT_STICKY_OFS) begin
      rd_next = sticky_flags;
    end else if (reg_addr == srsr_pkg::PIN_MIRROR_OFS) begin
      rd_next = pin_reg;
    end else if (reg_addr == srsr_pkg::RAW_TEMP_OFS) begin
      rd_next = temp_reg;
    end else if (reg_addr == srsr_pkg::RAW_SUPPLY_OFS) begin
      rd_next = supply_reg;
    end else if (reg_addr == srsr_pkg::RAW_BIAS_OFS) begin
      rd_next = bias_reg;
    end else if (reg_addr == srsr_pkg::RAW_TX_OPT_OFS) begin
      rd_next = tx_opt_reg;
    end else if (reg_addr == srsr_pkg::RAW_RX_OPT_OFS) begin
      rd_next = rx_opt_reg;
    end else if (reg_addr == srsr_pkg::RAW_PD_VOLT_OFS) begin
      rd_next = pd_volt_reg;
    end else if (reg_addr == srsr_pkg::SOFT_FAULT_OFS) begin
      rd_next = {7'h00, soft_fault_reg};
    end else begin
      rd_next = srsr_pkg::UNMAPPED_RD_VAL;
    end
  end

  // Read data registered; held until the next read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rd_data  <= srsr_pkg::REG_RESET_VAL;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= rd_next;
      end
    end
  end

endmodule : srsr_regs

`default_nettype wire

// [tb/srsr_regs_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checks of the status register bank
// ----------------------------------------
module srsr_regs_asserts (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       soft_fault_out,
  input wire logic       loader_idle,
  input wire logic       tx_powerup_done,
  input wire logic       rx_powerup_done,
  input wire logic       load_crc_fail,
  input wire logic       load_no_ack,
  input wire logic       flt_alarm,
  input wire logic       flt_rogue,
  input wire logic       flt_disable,
  input wire logic       flt_supply,
  input wire logic       flt_ref,
  input wire logic       flt_loop,
  input wire logic       flt_bias,
  input wire logic       laser_shutdown,
  input wire logic [7:0] raw_temp,
  input wire logic [7:0] raw_tx_opt
);
  // Soft bit masked: its timing follows the control write, not these inputs
  wire logic [7:0] flt_vec = {flt_alarm, flt_rogue, 1'b0, flt_disable,
                              flt_supply, flt_ref, flt_loop, flt_bias};
  // Expected init image, reserved bit 4 reads one
  wire logic [7:0] init_vec = {2'h0, loader_idle, 1'b1, tx_powerup_done,
                               rx_powerup_done, load_crc_fail, load_no_ack};
  wire logic       rd_sticky = reg_rd_en && reg_addr == srsr_pkg::FAULT_STICKY_OFS;
  wire logic       wr_sticky = reg_wr_en && reg_addr == srsr_pkg::FAULT_STICKY_OFS;
  wire logic       wr_soft   = reg_wr_en && reg_addr == srsr_pkg::SOFT_FAULT_OFS;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Stable inputs demanded so one cycle of latency slack never matters
  property p_init;
    reg_rd_en && reg_addr == srsr_pkg::INIT_PROGRESS_OFS && !$past(srst) && $stable(init_vec)
      |=> reg_rd_data == $past(init_vec);
  endproperty
  a_init: assert property (p_init) else $error("init flags wrong");
  property p_live;
    reg_rd_en && reg_addr == srsr_pkg::FAULT_LIVE_OFS && !$past(srst) && $stable(flt_vec)
      |=> (reg_rd_data & 8'hDF) == $past(flt_vec);
  endproperty
  a_live: assert property (p_live) else $error("live faults wrong");
  property p_shut;
    reg_rd_en && reg_addr == srsr_pkg::PIN_MIRROR_OFS && !$past(srst) && $stable(laser_shutdown)
      |=> reg_rd_data[2] == $past(laser_shutdown) && reg_rd_data[7:5] == 3'h0;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown mirror wrong");
  property p_temp;
    reg_rd_en && reg_addr == srsr_pkg::RAW_TEMP_OFS && !$past(srst) && $stable(raw_temp)
      |=> reg_rd_data == $past(raw_temp);
  endproperty
  a_temp: assert property (p_temp) else $error("raw temperature wrong");
  property p_txopt;
    reg_rd_en && reg_addr == srsr_pkg::RAW_TX_OPT_OFS && !$past(srst) && $stable(raw_tx_opt)
      |=> reg_rd_data == $past(raw_tx_opt);
  endproperty
  a_txopt: assert property (p_txopt) else $error("raw tx power wrong");
  property p_set;
    flt_bias [*3] ##1 (rd_sticky && !reg_wr_en) |=> reg_rd_data[0];
  endproperty
  a_set: assert property (p_set) else $error("sticky bit not set");
  // Fault falls in the clear cycle, so nothing re-sets the bit afterwards
  property p_keep;
    flt_bias [*2] ##1 (!flt_bias && wr_sticky && reg_wr_data[0]) ##1 !wr_sticky
      ##1 (rd_sticky && !reg_wr_en) |=> reg_rd_data[0];
  endproperty
  a_keep: assert property (p_keep) else $error("coincident clear lost event");
  property p_clear;
    (flt_vec == 8'h00 && !soft_fault_out) [*3] ##0 (wr_sticky && reg_wr_data == 8'hFF)
      ##1 (!wr_sticky && flt_vec == 8'h00 && !soft_fault_out)
      ##1 (rd_sticky && !reg_wr_en) |=> reg_rd_data == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("sticky clear failed");
  property p_soft;
    wr_soft ##1 !wr_soft ##1 !wr_soft |=> soft_fault_out == $past(reg_wr_data[0], 3);
  endproperty
  a_soft: assert property (p_soft) else $error("soft fault output wrong");

  c_rd_sticky: cover property (rd_sticky);
  c_wr_soft: cover property (wr_soft);
  c_keep: cover property (flt_bias ##1 (!flt_bias && wr_sticky));
endmodule : srsr_regs_asserts
`default_nettype wire

// [tb/srsr_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module srsr_host_model (
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid
);
  // Idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // One write strobe; idle lines then show the inverse so stale data is never reused
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask : wr
  // One read strobe; answer taken once the taking edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rd_data;
    v = reg_rd_valid;
  endtask : rd
endmodule : srsr_host_model
`default_nettype wire

// [tb/test_srsr_regs.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Register bank test sequence
// ----------------------------------------
module test_srsr_regs;
  logic       ref_clk, srst, reg_wr_en, reg_rd_en, reg_rd_valid, soft_fault_out;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, flt_drv;
  logic [4:0] init_drv, pin_drv;  // Loader flags; pins with shutdown at bit 2
  logic [7:0] raw_drv [6];        // Samples in offset order
  int         err_count, checks;
  localparam logic [7:0] RAW_OFS [6] = '{8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hEB};

  srsr_regs DUT (.ref_clk, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
    .reg_rd_data, .reg_rd_valid, .loader_idle(init_drv[4]), .tx_powerup_done(init_drv[3]),
    .rx_powerup_done(init_drv[2]), .load_crc_fail(init_drv[1]), .load_no_ack(init_drv[0]),
    .flt_alarm(flt_drv[7]), .flt_rogue(flt_drv[6]), .flt_disable(flt_drv[4]),
    .flt_supply(flt_drv[3]), .flt_ref(flt_drv[2]), .flt_loop(flt_drv[1]),
    .flt_bias(flt_drv[0]), .laser_shutdown(pin_drv[2]), .pin_sig_det(pin_drv[4]),
    .pin_tx_fault(pin_drv[3]), .pin_sleep(pin_drv[1]), .pin_tx_disable(pin_drv[0]),
    .raw_temp(raw_drv[0]), .raw_supply(raw_drv[1]), .raw_bias(raw_drv[2]),
    .raw_tx_opt(raw_drv[3]), .raw_rx_opt(raw_drv[4]), .raw_pd_volt(raw_drv[5]),
    .soft_fault_out);
  srsr_host_model host (.ref_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
    .reg_rd_data, .reg_rd_valid);

  // Free-running 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Read one offset, valid pulse checked with the data
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    check({name, " valid"}, {7'h00, v}, 8'h01);
    check(name, d, exp);
  endtask : rd_chk
  // Let pipelines and pin synchronisers catch up
  task automatic settle;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic complete_run;
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    logic [7:0] b;
    srst = 1'b1;
    init_drv = 5'h00;
    flt_drv = 8'h00;
    pin_drv = 5'h00;
    foreach (raw_drv[k]) raw_drv[k] = 8'h00;
    repeat (2) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    rd_chk("init", 8'hE0, 8'h10);
    check("soft out", {7'h00, soft_fault_out}, 8'h00);
    rd_chk("sticky", 8'hE2, 8'h00);
    // Each init flag alone, then all together
    for (int i = 0; i < 6; i++) begin
      init_drv = (i < 5) ? 5'h01 << i : 5'h1F;
      settle();
      rd_chk("init", 8'hE0, {2'h0, init_drv[4], 1'b1, init_drv[3:0]});
    end
    init_drv = 5'h00;
    settle();
    rd_chk("init", 8'hE0, 8'h10);
    // Each hardware fault: live, sticky, clear of others, own clear
    for (int i = 0; i < 8; i++) begin
      if (i == 5) continue;
      b = 8'h01 << i;
      flt_drv = b;
      settle();
      rd_chk("live", 8'hE1, b);
      flt_drv = 8'h00;
      settle();
      rd_chk("live", 8'hE1, 8'h00);
      rd_chk("sticky", 8'hE2, b);
      host.wr(8'hE2, ~b);
      rd_chk("sticky", 8'hE2, b);
      host.wr(8'hE2, b);
      rd_chk("sticky", 8'hE2, 8'h00);
    end
    // Software fault through the control bit
    host.wr(8'hC0, 8'h01);
    settle();
    check("soft out", {7'h00, soft_fault_out}, 8'h01);
    rd_chk("live", 8'hE1, 8'h20);
    host.wr(8'hC0, 8'h00);
    settle();
    rd_chk("live", 8'hE1, 8'h00);
    rd_chk("sticky", 8'hE2, 8'h20);
    host.wr(8'hE2, 8'hFF);
    rd_chk("sticky", 8'hE2, 8'h00);
    // Fault falls in the very cycle of its clear: the event must survive
    flt_drv = 8'h01;
    settle();
    rd_chk("sticky", 8'hE2, 8'h01);
    fork
      host.wr(8'hE2, 8'h01);
      begin
        @(posedge ref_clk);
        #1;
        flt_drv = 8'h00;
      end
    join
    rd_chk("sticky", 8'hE2, 8'h01);
    // Writes to read-only places are ignored
    host.wr(8'hE1, 8'hFF);
    host.wr(8'hE4, 8'hFF);
    rd_chk("live", 8'hE1, 8'h00);
    // Pin levels and shutdown, one at a time then all
    for (int i = 0; i < 6; i++) begin
      pin_drv = (i < 5) ? 5'h01 << i : 5'h1F;
      settle();
      rd_chk("pins", 8'hE4, {3'h0, pin_drv});
    end
    // Raw samples, distinct pattern then its inverse
    for (int p = 0; p < 2; p++) begin
      foreach (raw_drv[k]) raw_drv[k] = (p == 1) ? ~8'(8'h11 * (k + 1)) : 8'(8'h11 * (k + 1));
      settle();
      for (int k = 0; k < 3; k++) rd_chk("raw", RAW_OFS[k], raw_drv[k]);
      for (int k = 3; k < 6; k++) rd_chk("raw", RAW_OFS[k], raw_drv[k]);
    end
    rd_chk("unmapped", 8'hE3, 8'h00);
    complete_run();
  end
endmodule : test_srsr_regs

bind srsr_regs srsr_regs_asserts u_chk (.ref_clk, .srst, .reg_addr, .reg_wr_en, .reg_wr_data,
  .reg_rd_en, .reg_rd_data, .soft_fault_out, .loader_idle, .tx_powerup_done, .rx_powerup_done,
  .load_crc_fail, .load_no_ack, .flt_alarm, .flt_rogue, .flt_disable, .flt_supply, .flt_ref,
  .flt_loop, .flt_bias, .laser_shutdown, .raw_temp, .raw_tx_opt);
`default_nettype wire
